//--- include/iodr_pkg.sv
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`default_nettype none

package iodr_pkg;

    //--------------------------------------------------------------------------
    // register map
    //--------------------------------------------------------------------------
    localparam logic [6:0] ADDR_Y_ACCEL_LOW   = 7'h14;
    localparam logic [6:0] ADDR_Y_ACCEL_HIGH  = 7'h16;
    localparam logic [6:0] ADDR_Z_ACCEL_LOW   = 7'h18;
    localparam logic [6:0] ADDR_Z_ACCEL_HIGH  = 7'h1A;
    localparam logic [6:0] ADDR_DIE_TEMP      = 7'h1C;
    localparam logic [6:0] ADDR_SYNC_ELAPSED  = 7'h1E;
    localparam logic [6:0] ADDR_HOLE          = 7'h20;
    localparam logic [6:0] ADDR_UPDATE_CNT    = 7'h22;
    localparam logic [6:0] ADDR_X_DANG_LOW    = 7'h24;
    localparam logic [6:0] ADDR_X_DANG_HIGH   = 7'h26;
    localparam logic [6:0] ADDR_Y_DANG_LOW    = 7'h28;
    localparam logic [6:0] ADDR_Y_DANG_HIGH   = 7'h2A;
    localparam logic [6:0] ADDR_Z_DANG_LOW    = 7'h2C;
    localparam logic [6:0] ADDR_Z_DANG_HIGH   = 7'h2E;
    localparam logic [6:0] ADDR_LAST          = 7'h2F;
    localparam int         NUM_WORDS          = 14;
    localparam logic [15:0] UPD_CNT_RESET     = 16'h0000;
    localparam logic [15:0] UNMAPPED_DATA     = 16'h0000;

    //--------------------------------------------------------------------------
    // control fields and serial frame
    //--------------------------------------------------------------------------
    localparam int         SYNC_MODE_MSB      = 3;
    localparam int         SYNC_MODE_LSB      = 2;
    localparam logic [1:0] SYNC_MODE_SCALED   = 2'h2;
    localparam int         FRAME_BITS         = 16;
    localparam int         FRAME_RW_BIT       = 15;
    localparam int         FRAME_ADDR_MSB     = 14;
    localparam int         FRAME_ADDR_LSB     = 8;

    //--------------------------------------------------------------------------
    // timing and integration
    //--------------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS      = 10;
    localparam int         TS_LSB_NS          = 49020;
    localparam int         TS_TICK_CYC        = TS_LSB_NS / CLK_PERIOD_NS;
    localparam int         FS_NOMINAL_SPS     = 2000;
    localparam int         DANG_RANGE_DEG     = 360;
    localparam int         DANG_GAIN_POW      = 38;
    localparam int         DANG_SHIFT         = 24;
    localparam int         DANG_GAIN_W        = 24;
    localparam int         DANG_ACC_W         = 50;

    function automatic logic addr_mapped(input logic [6:0] addr);
        return (addr >= ADDR_Y_ACCEL_LOW) && (addr <= ADDR_LAST)
            && (addr[6:1] != ADDR_HOLE[6:1]);
    endfunction

    function automatic logic [5:0] word_index(input logic [6:0] addr);
        logic [6:0] off;
        off = addr - ADDR_Y_ACCEL_LOW;
        return off[6:1];
    endfunction

    // rate sum (deg/s q16) to delta angle counts of range/2^31
    function automatic logic [31:0] dang_scale(input logic signed [DANG_ACC_W-1:0] sum,
                                               input logic [DANG_GAIN_W-1:0] gain);
        logic signed [DANG_ACC_W+DANG_GAIN_W:0] prod;
        prod = sum * $signed({1'b0, gain});
        return prod[DANG_SHIFT+31:DANG_SHIFT];
    endfunction

endpackage : iodr_pkg

`default_nettype wire

//--- include/iodr_rd_if.sv
`default_nettype none

interface iodr_rd_if;
    logic        req;
    logic [6:0]  addr;
    logic [15:0] data;
    logic        ack;

    modport master (output req, output addr, input data, input ack);
    modport slave  (input req, input addr, output data, output ack);
endinterface : iodr_rd_if

`default_nettype wire

//--- core/iodr_regbank.sv
`default_nettype none

module iodr_regbank
    import iodr_pkg::*;
#(
    parameter int NW = NUM_WORDS
) (
    input  wire logic                 i_mclk,
    input  wire logic                 i_nrst,
    input  wire logic                 i_load,
    input  wire logic [NW-1:0][15:0]  i_words,
    iodr_rd_if.slave                  rd
);

    logic [NW-1:0][15:0] mem_reg;
    logic [15:0]         rdata_reg;
    logic                ack_reg;

    wire logic       hit = addr_mapped(rd.addr);
    wire logic [5:0] idx = word_index(rd.addr);
    wire logic [15:0] rdata_next = hit ? mem_reg[idx] : UNMAPPED_DATA;

    //--------------------------------------------------------------------------
    // all words load in one edge
    //--------------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            mem_reg <= '0;
        end else if (i_load) begin
            mem_reg <= i_words;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            rdata_reg <= 16'h0000;
            ack_reg   <= 1'b0;
        end else begin
            ack_reg <= rd.req;
            if (rd.req) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign rd.data = rdata_reg;
    assign rd.ack  = ack_reg;

endmodule : iodr_regbank

`default_nettype wire

//--- core/iodr_spi.sv
`default_nettype none

module iodr_spi
    import iodr_pkg::*;
(
    input  wire logic  i_mclk,
    input  wire logic  i_nrst,
    input  wire logic  i_cs_n,
    input  wire logic  i_sclk,
    input  wire logic  i_mosi,
    output logic       o_miso,
    output logic       o_miso_oe,
    iodr_rd_if.master  rd
);

    logic        sclk_prev_reg;
    logic        cs_prev_reg;
    logic [3:0]  bit_cnt_reg;
    logic [15:0] rx_reg;
    logic [15:0] tx_reg;
    logic [15:0] resp_reg;
    logic        req_reg;
    logic [6:0]  addr_reg;

    wire logic        sclk_rise  = i_sclk & ~sclk_prev_reg & ~i_cs_n;
    wire logic        sclk_fall  = ~i_sclk & sclk_prev_reg & ~i_cs_n;
    wire logic        cs_fall    = ~i_cs_n & cs_prev_reg;
    wire logic [15:0] rx_next    = {rx_reg[14:0], i_mosi};
    wire logic        frame_done = sclk_rise && (bit_cnt_reg == 4'(FRAME_BITS - 1));
    wire logic        is_read    = ~rx_next[FRAME_RW_BIT];

    //--------------------------------------------------------------------------
    // mode 3 frame: capture on rise, shift on fall
    //--------------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            sclk_prev_reg <= 1'b1;
            cs_prev_reg   <= 1'b1;
            bit_cnt_reg   <= 4'h0;
            rx_reg        <= 16'h0000;
        end else begin
            sclk_prev_reg <= i_sclk;
            cs_prev_reg   <= i_cs_n;
            if (i_cs_n) begin
                bit_cnt_reg <= 4'h0;
            end else if (sclk_rise) begin
                rx_reg      <= rx_next;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // read request goes out after the frame; answer shifts in the next one
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            req_reg  <= 1'b0;
            addr_reg <= 7'h00;
            resp_reg <= 16'h0000;
            tx_reg   <= 16'h0000;
        end else begin
            req_reg <= frame_done & is_read;
            if (frame_done) begin
                addr_reg <= rx_next[FRAME_ADDR_MSB:FRAME_ADDR_LSB];
            end
            if (frame_done && !is_read) begin
                resp_reg <= 16'h0000;
            end else if (rd.ack) begin
                resp_reg <= rd.data;
            end
            if (cs_fall) begin
                tx_reg <= resp_reg;
            end else if (sclk_fall && bit_cnt_reg != 4'h0) begin
                tx_reg <= {tx_reg[14:0], 1'b0};
            end
        end
    end

    assign rd.req    = req_reg;
    assign rd.addr   = addr_reg;
    assign o_miso    = tx_reg[15];
    assign o_miso_oe = ~i_cs_n;

endmodule : iodr_spi

`default_nettype wire

//--- core/iodr_top.sv
`default_nettype none

module iodr_top
    import iodr_pkg::*;
#(
    parameter int MODEL_RANGE_DEG = DANG_RANGE_DEG,
    parameter int FS_SPS          = FS_NOMINAL_SPS,
    parameter int TS_TICK_CYCLES  = TS_TICK_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_sample_stb,
    input  wire logic [31:0] i_gyro_x,
    input  wire logic [31:0] i_gyro_y,
    input  wire logic [31:0] i_gyro_z,
    input  wire logic [31:0] i_accel_y,
    input  wire logic [31:0] i_accel_z,
    input  wire logic [15:0] i_temp,
    input  wire logic        i_sync,
    input  wire logic [15:0] i_misc_ctrl,
    input  wire logic [15:0] i_dec_rate,
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic        i_mosi,
    output logic             o_miso,
    output logic             o_miso_oe,
    output logic             o_sample_available
);

    //--------------------------------------------------------------------------
    // integration gain per variant
    //--------------------------------------------------------------------------
    localparam longint unsigned GAIN_FULL =
        (64'd1 << DANG_GAIN_POW) / (64'(FS_SPS) * 64'(MODEL_RANGE_DEG));
    localparam logic [DANG_GAIN_W-1:0] DANG_GAIN = DANG_GAIN_W'(GAIN_FULL);
    localparam logic [15:0] TS_MAX = 16'hFFFF;

    iodr_rd_if rd_bus ();

    logic [15:0] dec_cnt_reg;
    logic [15:0] upd_cnt_reg;
    logic        sync_prev_reg;
    logic [31:0] tick_div_reg;
    logic [15:0] ts_cnt_reg;
    logic        avail_reg;
    logic signed [31:0]           rate_prev_reg [3];
    logic signed [DANG_ACC_W-1:0] acc_reg [3];
    logic signed [DANG_ACC_W-1:0] acc_next [3];
    logic [31:0]                  dang [3];
    logic [NUM_WORDS-1:0][15:0]   words;

    wire logic signed [31:0] rate_in [3] = '{i_gyro_x, i_gyro_y, i_gyro_z};

    //--------------------------------------------------------------------------
    // decimation and update strobe
    //--------------------------------------------------------------------------
    wire logic        last_sample = dec_cnt_reg >= i_dec_rate;
    wire logic        update      = i_sample_stb & last_sample;
    wire logic        sync_rise   = i_sync & ~sync_prev_reg;
    wire logic        tick        = tick_div_reg >= 32'(TS_TICK_CYCLES - 1);
    wire logic [1:0]  sync_mode   = i_misc_ctrl[SYNC_MODE_MSB:SYNC_MODE_LSB];
    wire logic        ts_valid    = sync_mode == SYNC_MODE_SCALED;
    wire logic [15:0] ts_now      = sync_rise ? 16'h0000 : ts_cnt_reg;
    wire logic [15:0] upd_cnt_nxt = upd_cnt_reg + 16'h0001;

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            dec_cnt_reg <= 16'h0000;
        end else if (update) begin
            dec_cnt_reg <= 16'h0000;
        end else if (i_sample_stb) begin
            dec_cnt_reg <= dec_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            upd_cnt_reg <= UPD_CNT_RESET;
            avail_reg   <= 1'b0;
        end else begin
            avail_reg <= update;
            if (update) begin
                upd_cnt_reg <= upd_cnt_nxt;
            end
        end
    end

    //--------------------------------------------------------------------------
    // time since last sync edge
    //--------------------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            sync_prev_reg <= 1'b0;
            tick_div_reg  <= 32'h0000_0000;
            ts_cnt_reg    <= 16'h0000;
        end else begin
            sync_prev_reg <= i_sync;
            if (sync_rise) begin
                tick_div_reg <= 32'h0000_0000;
                ts_cnt_reg   <= 16'h0000;
            end else if (tick) begin
                tick_div_reg <= 32'h0000_0000;
                if (ts_cnt_reg != TS_MAX) begin
                    ts_cnt_reg <= ts_cnt_reg + 16'h0001;
                end
            end else begin
                tick_div_reg <= tick_div_reg + 32'h0000_0001;
            end
        end
    end

    //--------------------------------------------------------------------------
    // delta angle: trapezoid sum over the decimation window
    //--------------------------------------------------------------------------
    always_comb begin
        for (int a = 0; a < 3; a++) begin
            acc_next[a] = acc_reg[a]
                        + DANG_ACC_W'(rate_in[a])
                        + DANG_ACC_W'(rate_prev_reg[a]);
            dang[a]     = dang_scale(acc_next[a], DANG_GAIN);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            for (int a = 0; a < 3; a++) begin
                rate_prev_reg[a] <= 32'h0000_0000;
                acc_reg[a]       <= '0;
            end
        end else if (i_sample_stb) begin
            for (int a = 0; a < 3; a++) begin
                rate_prev_reg[a] <= rate_in[a];
                acc_reg[a]       <= update ? '0 : acc_next[a];
            end
        end
    end

    //--------------------------------------------------------------------------
    // output words, loaded together on each update
    //--------------------------------------------------------------------------
    always_comb begin
        words = '0;
        words[word_index(ADDR_Y_ACCEL_LOW)]  = i_accel_y[15:0];
        words[word_index(ADDR_Y_ACCEL_HIGH)] = i_accel_y[31:16];
        words[word_index(ADDR_Z_ACCEL_LOW)]  = i_accel_z[15:0];
        words[word_index(ADDR_Z_ACCEL_HIGH)] = i_accel_z[31:16];
        words[word_index(ADDR_DIE_TEMP)]     = i_temp;
        words[word_index(ADDR_SYNC_ELAPSED)] = ts_valid ? ts_now : 16'h0000;
        words[word_index(ADDR_UPDATE_CNT)]   = upd_cnt_nxt;
        words[word_index(ADDR_X_DANG_LOW)]   = dang[0][15:0];
        words[word_index(ADDR_X_DANG_HIGH)]  = dang[0][31:16];
        words[word_index(ADDR_Y_DANG_LOW)]   = dang[1][15:0];
        words[word_index(ADDR_Y_DANG_HIGH)]  = dang[1][31:16];
        words[word_index(ADDR_Z_DANG_LOW)]   = dang[2][15:0];
        words[word_index(ADDR_Z_DANG_HIGH)]  = dang[2][31:16];
    end

    iodr_regbank #(
        .NW      (NUM_WORDS)
    ) u_regbank (
        .i_mclk  (i_mclk),
        .i_nrst  (i_nrst),
        .i_load  (update),
        .i_words (words),
        .rd      (rd_bus.slave)
    );

    iodr_spi u_spi (
        .i_mclk    (i_mclk),
        .i_nrst    (i_nrst),
        .i_cs_n    (i_cs_n),
        .i_sclk    (i_sclk),
        .i_mosi    (i_mosi),
        .o_miso    (o_miso),
        .o_miso_oe (o_miso_oe),
        .rd        (rd_bus.master)
    );

    // pulse once the new words are readable; host rate measurement uses it
    assign o_sample_available = avail_reg;

endmodule : iodr_top

`default_nettype wire

//--- tb/iodr_assertions.sv
`default_nettype none

module iodr_chk (
    input  wire logic        i_mclk,
    input  wire logic        i_nrst,
    input  wire logic        i_sample_stb,
    input  wire logic [15:0] i_dec_rate,
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic        o_miso,
    input  wire logic        o_miso_oe,
    input  wire logic        o_sample_available
);
    //--------------------------------------------------------------------------
    // strobes seen since the last update
    //--------------------------------------------------------------------------
    logic [16:0] grp_reg;
    logic [16:0] grp_next;
    wire  [16:0] grp_eff;

    assign grp_eff  = o_sample_available ? 17'h00000 : grp_reg;
    assign grp_next = grp_eff + {16'h0000, i_sample_stb};

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) grp_reg <= 17'h00000;
        else grp_reg <= grp_next;
    end

    //--------------------------------------------------------------------------
    // properties
    //--------------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);

    oe_follows_cs_a: assert property (o_miso_oe == !i_cs_n)
        else $error("miso enable does not follow chip select");
    avail_needs_strobe_a: assert property (o_sample_available |-> $past(i_sample_stb))
        else $error("update flagged without a sample strobe");
    update_on_count_a: assert property (
        i_sample_stb && grp_eff == {1'b0, i_dec_rate} |=> o_sample_available)
        else $error("no update after the last sample of a group");
    no_early_update_a: assert property (
        i_sample_stb && grp_eff < {1'b0, i_dec_rate} |=> !o_sample_available)
        else $error("update before the group is complete");
    group_bounded_a: assert property (grp_eff <= {1'b0, i_dec_rate})
        else $error("more strobes than one group without an update");
    miso_holds_high_a: assert property (
        !i_cs_n && $rose(i_sclk) ##1 (i_sclk && !i_cs_n) [*3] |-> $stable(o_miso))
        else $error("miso moved while the serial clock was high");
    reset_clears_avail_a: assert property (disable iff (1'b0)
        !i_nrst |=> !o_sample_available)
        else $error("update flag set out of reset");
    reset_clears_miso_a: assert property (disable iff (1'b0) !i_nrst |=> !o_miso)
        else $error("miso not low out of reset");

    cover property (o_sample_available && i_dec_rate == 16'h0001);
    cover property (i_sample_stb && o_sample_available);
    cover property ($rose(i_cs_n));
endmodule // iodr_chk

bind iodr_top iodr_chk u_chk (
    .i_mclk            (i_mclk),
    .i_nrst            (i_nrst),
    .i_sample_stb      (i_sample_stb),
    .i_dec_rate        (i_dec_rate),
    .i_cs_n            (i_cs_n),
    .i_sclk            (i_sclk),
    .o_miso            (o_miso),
    .o_miso_oe         (o_miso_oe),
    .o_sample_available(o_sample_available)
);

`default_nettype wire

//--- tb/iodr_host.sv
`default_nettype none

module iodr_host (
    input  wire logic i_mclk,
    input  wire logic i_miso,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_mosi
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_mosi = 1'b0;
    end

    //--------------------------------------------------------------------------
    // one 16-bit frame, mode 3, msb first
    //--------------------------------------------------------------------------
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        @(posedge i_mclk);
        o_cs_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        for (int i = 15; i >= 0; i--) begin
            o_sclk <= 1'b0;
            o_mosi <= cmd[i];
            repeat (4) @(posedge i_mclk);
            o_sclk <= 1'b1;
            rsp[i] = i_miso;
            repeat (4) @(posedge i_mclk);
        end
        o_cs_n <= 1'b1;
        // released line has no pull: never leave the last bit showing
        o_mosi <= ~o_mosi;
        repeat (6) @(posedge i_mclk);
    endtask
endmodule // iodr_host

`default_nettype wire

//--- tb/iodr_top_tb.sv
`default_nettype none

module iodr_top_tb import iodr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int     TICK  = 5;
    localparam int     RANGE = 360;
    localparam int     FS    = 2000;
    localparam longint WL    = 23592960;
    localparam longint ZL    = 1048576;

    logic        i_mclk;
    logic        i_nrst;
    logic        i_sample_stb;
    logic [31:0] i_gyro_x;
    logic [31:0] i_gyro_y;
    logic [31:0] i_gyro_z;
    logic [31:0] i_accel_y;
    logic [31:0] i_accel_z;
    logic [15:0] i_temp;
    logic        i_sync;
    logic [15:0] i_misc_ctrl;
    logic [15:0] i_dec_rate;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        o_miso;
    logic        o_miso_oe;
    logic        o_sample_available;
    wire         miso_w;
    int          fail_count;
    int          comparisons;
    int          avail_count;
    logic [15:0] rv;
    logic [31:0] dx;
    logic [31:0] dy;
    logic [31:0] dz;
    logic [6:0]  qa[$];
    logic [15:0] qe[$];

    assign miso_w = o_miso_oe ? o_miso : 1'bz;

    // host side count of cycles with sample-available high: one per update, even where back-to-back updates merge into one pulse
    always @(posedge i_mclk) begin
        if (o_sample_available) begin
            avail_count <= avail_count + 1;
        end
    end

    iodr_top #(.MODEL_RANGE_DEG(RANGE), .FS_SPS(FS), .TS_TICK_CYCLES(TICK)) dut (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_sample_stb(i_sample_stb),
        .i_gyro_x(i_gyro_x), .i_gyro_y(i_gyro_y), .i_gyro_z(i_gyro_z),
        .i_accel_y(i_accel_y), .i_accel_z(i_accel_z), .i_temp(i_temp),
        .i_sync(i_sync), .i_misc_ctrl(i_misc_ctrl), .i_dec_rate(i_dec_rate),
        .i_cs_n(cs_n), .i_sclk(sclk), .i_mosi(mosi), .o_miso(o_miso),
        .o_miso_oe(o_miso_oe), .o_sample_available(o_sample_available));

    iodr_host host (.i_mclk(i_mclk), .i_miso(miso_w), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_mosi(mosi));

    //--------------------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: read %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        logic [15:0] junk;
        host.xfer({1'b0, a, 8'h00}, junk);
        host.xfer(16'h0000, d);
    endtask

    task automatic rd_all();
        logic [15:0] d;
        foreach (qa[i]) begin
            rd(qa[i], d);
            chk(d, qe[i]);
        end
    endtask

    task automatic pulse(input int n);
        @(posedge i_mclk);
        i_sample_stb <= 1'b1;
        repeat (n) @(posedge i_mclk);
        i_sample_stb <= 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask

    function automatic logic [31:0] dang(input longint s);
        longint g;
        g = (longint'(1) << 38) / (FS * RANGE);
        return 32'((s * g) >>> 24);
    endfunction

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    //--------------------------------------------------------------------------
    // clock, watchdog, tests
    //--------------------------------------------------------------------------
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    initial begin
        repeat (90000) @(posedge i_mclk);
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        {i_nrst, i_sample_stb, i_sync} = 3'b000;
        {i_gyro_x, i_gyro_y, i_gyro_z, i_accel_y, i_accel_z} = '0;
        {i_temp, i_misc_ctrl, i_dec_rate} = '0;
        fail_count = 0;
        comparisons = 0;
        avail_count = 0;
        repeat (3) @(posedge i_mclk);
        i_nrst <= 1'b1;
        qa = '{ADDR_UPDATE_CNT, ADDR_Y_ACCEL_HIGH};
        qe = '{16'h0000, 16'h0000};
        rd_all();
        $display("test reset done");
        @(posedge i_mclk);
        i_gyro_x <= 32'(WL);
        i_gyro_y <= 32'(-WL);
        i_gyro_z <= 32'(ZL);
        i_accel_y <= 32'h7D00ABCD;
        i_accel_z <= 32'h83001234;
        i_temp <= 16'hFE70;
        pulse(1);
        dx = dang(WL);
        dy = dang(-WL);
        dz = dang(ZL);
        qa = '{ADDR_Y_ACCEL_LOW, ADDR_Y_ACCEL_HIGH, ADDR_Z_ACCEL_LOW, ADDR_Z_ACCEL_HIGH,
               ADDR_DIE_TEMP, ADDR_UPDATE_CNT, 7'h17, ADDR_X_DANG_LOW, ADDR_X_DANG_HIGH,
               ADDR_Y_DANG_LOW, ADDR_Y_DANG_HIGH, ADDR_Z_DANG_LOW, ADDR_Z_DANG_HIGH};
        qe = '{16'hABCD, 16'h7D00, 16'h1234, 16'h8300, 16'hFE70, 16'h0001, 16'h7D00,
               dx[15:0], dx[31:16], dy[15:0], dy[31:16], dz[15:0], dz[31:16]};
        rd_all();
        $display("test single update done");
        i_dec_rate <= 16'h0001;
        pulse(1);
        qa = '{ADDR_UPDATE_CNT};
        qe = '{16'h0001};
        rd_all();
        i_accel_y <= 32'hFFFF0001;
        pulse(1);
        dx = dang(4 * WL);
        dy = dang(-4 * WL);
        dz = dang(4 * ZL);
        qa = '{ADDR_UPDATE_CNT, ADDR_Y_ACCEL_LOW, ADDR_Y_ACCEL_HIGH, ADDR_X_DANG_LOW,
               ADDR_X_DANG_HIGH, ADDR_Y_DANG_LOW, ADDR_Y_DANG_HIGH, ADDR_Z_DANG_HIGH};
        qe = '{16'h0002, 16'h0001, 16'hFFFF, dx[15:0], dx[31:16], dy[15:0], dy[31:16],
               dz[31:16]};
        rd_all();
        $display("test decimation done");
        i_dec_rate <= 16'h0000;
        i_misc_ctrl <= 16'h0008;
        i_sync <= 1'b1;
        repeat (52) @(posedge i_mclk);
        pulse(1);
        i_misc_ctrl <= 16'h0000;
        qa = '{ADDR_SYNC_ELAPSED, ADDR_UPDATE_CNT};
        qe = '{16'h000A, 16'h0003};
        rd_all();
        pulse(1);
        qa = '{ADDR_SYNC_ELAPSED};
        qe = '{16'h0000};
        rd_all();
        $display("test time stamp done");
        rv = 16'(avail_count);
        pulse(65531);
        chk(16'(avail_count) - rv, 16'hFFFB);
        qa = '{ADDR_UPDATE_CNT};
        qe = '{16'hFFFF};
        rd_all();
        pulse(1);
        qe = '{16'h0000};
        rd_all();
        $display("test counter wrap done");
        pulse(1);
        i_nrst <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_nrst <= 1'b1;
        pulse(1);
        qe = '{16'h0001};
        rd_all();
        $display("test mid-run reset done");
        host.xfer({1'b1, ADDR_Y_ACCEL_HIGH, 8'h55}, rv);
        host.xfer(16'h0000, rv);
        chk(rv, 16'h0000);
        qa = '{7'h20, 7'h10, 7'h30, ADDR_Y_ACCEL_HIGH};
        qe = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF};
        rd_all();
        $display("test refused access done");
        summarize();
    end
endmodule // iodr_top_tb

`default_nettype wire
